//--- rtl/lrq_pkg.sv
// Shared constants for the link request serialiser
package lrq_pkg;
	localparam int LRQ_CLK_MHZ = 20;
	localparam int LRQ_BUS_LEN = 7;
	localparam int LRQ_RD_LEN = 9;
	localparam int LRQ_WR_LEN = 17;
	localparam int LRQ_TYPE_POS = 1;
	localparam int LRQ_SPD_POS = 4;
	localparam int LRQ_ADDR_POS = 4;
	localparam int LRQ_DATA_POS = 8;
	localparam logic [2:0] LRQ_IMMEDIATE = 3'h0;
	localparam logic [2:0] LRQ_ISOCHRONOUS = 3'h1;
	localparam logic [2:0] LRQ_PRIORITY = 3'h2;
	localparam logic [2:0] LRQ_FAIR = 3'h3;
	localparam logic [2:0] LRQ_REG_READ = 3'h4;
	localparam logic [2:0] LRQ_REG_WRITE = 3'h5;
	localparam logic [1:0] LRQ_CTL_IDLE = 2'h0;
	localparam logic [1:0] LRQ_CTL_STATUS = 2'h1;
	localparam logic [1:0] LRQ_CTL_RECEIVE = 2'h2;
	localparam logic [1:0] LRQ_CTL_GRANT = 2'h3;
	localparam int LRQ_ACK_WAIT_NS = 160;
	localparam int LRQ_ACK_WAIT_CYC = (LRQ_ACK_WAIT_NS * LRQ_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] LRQ_OFF_CMD = 8'h00;
	localparam logic [7:0] LRQ_OFF_STAT = 8'h04;
	localparam logic [7:0] LRQ_OFF_LOST = 8'h08;
	localparam logic [1:0] LRQ_RESP_OKAY = 2'h0;
	localparam logic [1:0] LRQ_RESP_SLVERR = 2'h2;
endpackage

//--- rtl/lrq_sync.sv
// Two-stage synchroniser for the control lines
`timescale 1ns/1ns
module lrq_sync import lrq_pkg::*; (
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, low
	input wire logic [1:0] d_in, // async input
	output logic [1:0] q_out // synchronised
);
	logic [1:0] s1_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= 2'h0;
			q_out <= 2'h0;
		end else begin
			s1_reg <= d_in;
			q_out <= s1_reg;
		end
	end
endmodule

//--- rtl/lrq_shift.sv
// Serialiser that sends one request frame, lowest bit first
`timescale 1ns/1ns
module lrq_shift import lrq_pkg::*; (
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, low
	input wire logic load, // start a frame
	input wire logic [16:0] frame, // frame bits, start at bit 0
	input wire logic [4:0] len, // frame length in bits
	output logic line_out, // serial request line
	output logic busy // frame under way
);
	logic [16:0] sh_reg;
	logic [4:0] cnt_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sh_reg <= 17'h0;
			cnt_reg <= 5'h0;
		end else if (load && cnt_reg == 5'h0) begin
			sh_reg <= frame;
			cnt_reg <= len;
		end else if (cnt_reg != 5'h0) begin
			sh_reg <= {1'b0, sh_reg[16:1]};
			cnt_reg <= cnt_reg - 5'h1;
		end
	end
	// upper frame bits are zero, so the line rests low after the stop bit
	assign line_out = sh_reg[0];
	assign busy = cnt_reg != 5'h0;
endmodule

//--- rtl/lrq_host.sv
// Link-side request controller with AXI4-Lite command registers
`timescale 1ns/1ns
module lrq_host import lrq_pkg::*; (
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, low
	input wire logic [31:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	input wire logic [1:0] interface_control_lines, // control lines from device
	output logic link_request_line // serial request line
);
	typedef enum {LRQ_S_IDLE, LRQ_S_WAIT, LRQ_S_SEND, LRQ_S_WATCH, LRQ_S_ACKWAIT} lrq_state_t;

	lrq_state_t state_reg;
	logic [1:0] ctl_s;
	logic [1:0] ctl_prev_reg;
	logic [2:0] type_reg;
	logic [1:0] spd_reg;
	logic [3:0] addr_reg;
	logic [7:0] data_reg;
	logic pend_reg;
	logic lost_reg;
	logic won_reg;
	logic sent_reg;
	logic [7:0] lost_cnt_reg;
	logic [3:0] ack_cnt_reg;
	logic [16:0] frame;
	logic [4:0] frame_len;
	logic load;
	logic busy;
	logic aw_got_reg, w_got_reg;
	logic [7:0] aw_off_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic cmd_wr;

	function automatic logic is_bus_req(input logic [2:0] t);
		return t <= LRQ_FAIR;
	endfunction

	function automatic logic needs_idle(input logic [2:0] t);
		return t == LRQ_PRIORITY || t == LRQ_FAIR;
	endfunction

	function automatic logic wr_hit(input logic [7:0] off, input logic [7:0] want,
		input logic [3:0] strb);
		return off == want && strb[0];
	endfunction

	lrq_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d_in(interface_control_lines),
		.q_out(ctl_s)
	);

	always_comb begin
		frame = 17'h0;
		frame[0] = 1'b1;
		frame[LRQ_TYPE_POS +: 3] = type_reg;
		if (is_bus_req(type_reg)) begin
			// speed field, stop bit stays zero
			frame[LRQ_SPD_POS +: 2] = spd_reg;
			frame_len = 5'(LRQ_BUS_LEN);
		end else if (type_reg == LRQ_REG_READ) begin
			frame[LRQ_ADDR_POS +: 4] = addr_reg;
			frame_len = 5'(LRQ_RD_LEN);
		end else begin
			frame[LRQ_ADDR_POS +: 4] = addr_reg;
			frame[LRQ_DATA_POS +: 8] = data_reg;
			frame_len = 5'(LRQ_WR_LEN);
		end
	end

	lrq_shift u_shift (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(load),
		.frame(frame),
		.len(frame_len),
		.line_out(link_request_line),
		.busy(busy)
	);

	// One load per entry into LRQ_S_SEND; a free-running load would resend the frame forever
	assign load = state_reg == LRQ_S_SEND && !busy && !sent_reg;

	// frame sent once per entry into LRQ_S_SEND, stop bit always ends it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sent_reg <= 1'b0;
		end else if (load) begin
			sent_reg <= 1'b1;
		end else if (state_reg != LRQ_S_SEND) begin
			sent_reg <= 1'b0;
		end
	end

	// Two idle samples in a row give the idle clock before fair or priority
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_prev_reg <= LRQ_CTL_IDLE;
		end else begin
			ctl_prev_reg <= ctl_s;
		end
	end

	// AXI write channel: address and data may arrive in either order
	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
	assign cmd_wr = aw_got_reg && w_got_reg && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_off_reg <= 8'h0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= LRQ_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				aw_off_reg <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (cmd_wr) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Upper address bits are not decoded, so aliases answer too
				if (aw_off_reg == LRQ_OFF_CMD || aw_off_reg == LRQ_OFF_LOST) begin
					s_axi_bresp <= LRQ_RESP_OKAY;
				end else begin
					s_axi_bresp <= LRQ_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Command engine; a command written while pending is dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= LRQ_S_IDLE;
			type_reg <= LRQ_IMMEDIATE;
			spd_reg <= 2'h0;
			addr_reg <= 4'h0;
			data_reg <= 8'h0;
			pend_reg <= 1'b0;
			lost_reg <= 1'b0;
			won_reg <= 1'b0;
			lost_cnt_reg <= 8'h0;
			ack_cnt_reg <= 4'h0;
		end else begin
			if (cmd_wr && wr_hit(aw_off_reg, LRQ_OFF_LOST, w_strb_reg)) begin
				lost_reg <= 1'b0;
				won_reg <= 1'b0;
				lost_cnt_reg <= 8'h0;
			end
			unique case (state_reg)
				LRQ_S_IDLE: begin
					// priority code kept for cycle start
					if (cmd_wr && wr_hit(aw_off_reg, LRQ_OFF_CMD, w_strb_reg)
						&& w_data_reg[2:0] <= LRQ_REG_WRITE) begin
						type_reg <= w_data_reg[2:0];
						// only 100 and 200 speed codes
						spd_reg <= {1'b0, w_data_reg[4]};
						addr_reg <= w_data_reg[11:8];
						data_reg <= w_data_reg[23:16];
						pend_reg <= 1'b1;
						won_reg <= 1'b0;
						state_reg <= LRQ_S_WAIT;
					end
				end
				LRQ_S_WAIT: begin
					// iso and immediate go at once
					// one idle clock before fair or priority
					// Shifter empty, so the idle samples are still fresh at launch
					if (!busy && (!needs_idle(type_reg)
						|| (ctl_s == LRQ_CTL_IDLE && ctl_prev_reg == LRQ_CTL_IDLE))) begin
						state_reg <= LRQ_S_SEND;
					end
				end
				LRQ_S_SEND: begin
					// receive during shifting loses a fair or priority request
					if (needs_idle(type_reg) && busy && ctl_s == LRQ_CTL_RECEIVE) begin
						lost_reg <= 1'b1;
						lost_cnt_reg <= lost_cnt_reg + 8'h1;
						state_reg <= LRQ_S_WAIT;
					end else if (sent_reg && !busy) begin
						if (is_bus_req(type_reg)) begin
							state_reg <= LRQ_S_WATCH;
						end else begin
							pend_reg <= 1'b0;
							state_reg <= LRQ_S_IDLE;
						end
					end
				end
				LRQ_S_WATCH: begin
					// grant code ends the wait as won
					// grant never held; bus freed at once except after an immediate request, which waits in LRQ_S_ACKWAIT
					if (ctl_s == LRQ_CTL_GRANT) begin
						won_reg <= 1'b1;
						pend_reg <= 1'b0;
						ack_cnt_reg <= 4'h0;
						state_reg <= (type_reg == LRQ_IMMEDIATE) ? LRQ_S_ACKWAIT : LRQ_S_IDLE;
					end else if (ctl_s == LRQ_CTL_RECEIVE && type_reg != LRQ_IMMEDIATE
						&& type_reg != LRQ_ISOCHRONOUS) begin
						lost_reg <= 1'b1;
						lost_cnt_reg <= lost_cnt_reg + 8'h1;
						state_reg <= LRQ_S_WAIT;
					end
				end
				LRQ_S_ACKWAIT: begin
					// hold off new requests after an acknowledge grant
					if (ack_cnt_reg == 4'(LRQ_ACK_WAIT_CYC - 1)) begin
						state_reg <= LRQ_S_IDLE;
					end else begin
						ack_cnt_reg <= ack_cnt_reg + 4'h1;
					end
				end
			endcase
		end
	end

	// AXI read channel
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= LRQ_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= LRQ_RESP_OKAY;
			unique case (s_axi_araddr[7:0])
				LRQ_OFF_CMD: s_axi_rdata <= {8'h0, data_reg, 4'h0, addr_reg, 3'h0,
					spd_reg[0], 1'b0, type_reg};
				LRQ_OFF_STAT: s_axi_rdata <= {24'h0, ctl_s, busy, won_reg, lost_reg,
					pend_reg, state_reg == LRQ_S_IDLE, 1'b0};
				LRQ_OFF_LOST: s_axi_rdata <= {24'h0, lost_cnt_reg};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= LRQ_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

//--- verif/lrq_host_assertions.sv
// Port checker for the link request controller
`timescale 1ns/1ns
module lrq_host_assertions import lrq_pkg::*; (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, low
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic [1:0] s_axi_bresp, // b resp
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic [1:0] interface_control_lines, // control code
	input wire logic link_request_line // request line
);
	logic [4:0] pos_reg;
	logic [2:0] typ_reg;
	logic [4:0] flen;
	logic last_bit;
	assign flen = typ_reg[2] ? (typ_reg[0] ? 5'h11 : 5'h09) : 5'h07;
	assign last_bit = (pos_reg != 5'h0) && (pos_reg == flen - 5'h1);
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pos_reg <= 5'h0;
		else if (pos_reg == 5'h0)
			pos_reg <= {4'h0, link_request_line};
		else if (last_bit)
			pos_reg <= 5'h0;
		else
			pos_reg <= pos_reg + 5'h1;
	end
	// Type bits known from position four on
	always_ff @(posedge aclk) begin
		if (pos_reg >= 5'h1 && pos_reg <= 5'h3)
			typ_reg[pos_reg - 5'h1] <= link_request_line;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_stop_zero: assert property (last_bit |-> !link_request_line)
		else $error("stop bit not zero");
	a_gap_after: assert property (last_bit |=> !link_request_line)
		else $error("no gap after frame");
	a_type_legal: assert property (pos_reg == 5'h4 |-> !(typ_reg[2] && typ_reg[1]))
		else $error("reserved type sent");
	a_speed_low: assert property (pos_reg == 5'h5 && !typ_reg[2] |-> !link_request_line)
		else $error("unsupported speed");
	// Launch judged on two synchronised samples taken eight and nine edges back
	a_fair_idle: assert property (pos_reg == 5'h4 && typ_reg[2:1] == 2'h1
		|-> $past(interface_control_lines, 8) == LRQ_CTL_IDLE
		&& $past(interface_control_lines, 9) == LRQ_CTL_IDLE)
		else $error("fair or priority not after idle");
	a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	c_write: cover property (pos_reg == 5'h4 && typ_reg == LRQ_REG_WRITE);
	c_fair: cover property (pos_reg == 5'h4 && typ_reg == LRQ_FAIR);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind lrq_host lrq_host_assertions lrq_host_assertions_i (.aclk, .aresetn, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .interface_control_lines, .link_request_line);

//--- verif/lrq_dev_model.sv
// Behavioural device decoding the serial request line
`timescale 1ns/1ns
module lrq_dev_model import lrq_pkg::*; (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, low
	input wire logic link_request_line, // request line
	input wire logic lose, // show receive, not grant
	input wire logic [3:0] delay, // answer delay
	output logic [1:0] interface_control_lines, // control code
	output logic [16:0] last_frame, // last frame
	output logic [7:0] frames, // frame count
	output logic [15:0][7:0] regs // register file
);
	logic [16:0] sh_reg;
	logic [4:0] n_reg;
	logic done_reg;
	logic pend_reg;
	logic [3:0] cnt_reg;
	logic [1:0] hold_reg;
	logic [2:0] t;
	logic [4:0] flen;
	assign t = sh_reg[3:1];
	assign flen = sh_reg[3] ? (sh_reg[1] ? 5'h11 : 5'h09) : 5'h07;
	always_ff @(posedge aclk) begin
		done_reg <= 1'b0;
		if (!aresetn)
			n_reg <= 5'h0;
		else if (n_reg == 5'h0 && link_request_line) begin
			sh_reg <= 17'h1;
			n_reg <= 5'h1;
		end else if (n_reg != 5'h0) begin
			sh_reg[n_reg] <= link_request_line;
			n_reg <= (n_reg == flen - 5'h1) ? 5'h0 : n_reg + 5'h1;
			done_reg <= (n_reg == flen - 5'h1);
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			interface_control_lines <= LRQ_CTL_IDLE;
			pend_reg <= 1'b0;
			hold_reg <= 2'h0;
			frames <= 8'h0;
		end else begin
			if (done_reg) begin
				frames <= frames + 8'h1;
				last_frame <= sh_reg;
			end
			if (hold_reg == 2'h1)
				interface_control_lines <= LRQ_CTL_IDLE;
			if (hold_reg != 2'h0)
				hold_reg <= hold_reg - 2'h1;
			if (done_reg && t == LRQ_REG_WRITE)
				regs[sh_reg[7:4]] <= sh_reg[15:8];
			if (done_reg && !t[2] && !pend_reg) begin
				pend_reg <= 1'b1;
				cnt_reg <= delay;
			end
			if (pend_reg && cnt_reg != 4'h0)
				cnt_reg <= cnt_reg - 4'h1;
			if (pend_reg && cnt_reg == 4'h0) begin
				pend_reg <= 1'b0;
				interface_control_lines <= lose ? LRQ_CTL_RECEIVE : LRQ_CTL_GRANT;
				hold_reg <= lose ? 2'h3 : 2'h1;
			end
			if (done_reg && t == LRQ_REG_READ) begin
				interface_control_lines <= LRQ_CTL_STATUS;
				hold_reg <= 2'h2;
			end
		end
	end
endmodule

//--- verif/link_request_decoder_test.sv
// Self-checking bench for the link request controller
`timescale 1ns/1ns
module link_request_decoder_test import lrq_pkg::*;;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, lose = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf, delay = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic link_request_line;
	logic [1:0] s_axi_bresp, s_axi_rresp, interface_control_lines;
	logic [16:0] last_frame;
	logic [7:0] frames;
	logic [15:0][7:0] regs;
	logic [31:0] seed = 32'h6fe8;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	lrq_host lrq_host_i (.*);
	lrq_dev_model lrq_dev_model_i (.*);
	always #25 aclk = ~aclk;
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Ceiling well above the longest expected run
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [16:0] exp_frame(input logic [2:0] t, input logic [3:0] a,
		input logic [7:0] v, input logic s);
		if (t[2])
			return {t[0] ? {1'b0, v} : 9'h0, a, t, 1'b1};
		return {11'h0, 1'b0, s, t, 1'b1};
	endfunction
	// Ready flags are combinational, so handshakes are judged before the edge
	// Response ready stays high between transfers, a legal idle level
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ka, kw, kb;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		kb = 1'b0;
		while (!kb) begin
			@(negedge aclk);
			ka = s_axi_awvalid && s_axi_awready;
			kw = s_axi_wvalid && s_axi_wready;
			kb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ka) s_axi_awvalid <= 1'b0;
			if (kw) s_axi_wvalid <= 1'b0;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ka, kr;
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		kr = 1'b0;
		while (!kr) begin
			@(negedge aclk);
			ka = s_axi_arvalid && s_axi_arready;
			kr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ka) s_axi_arvalid <= 1'b0;
		end
	endtask
	task automatic settle(input logic [7:0] f, output logic [31:0] d);
		logic [1:0] r;
		while (frames != f) @(posedge aclk);
		d = 32'h0;
		while (!d[1]) rd(LRQ_OFF_STAT, d, r);
	endtask
	task automatic req(input logic [2:0] t, input logic [3:0] a, input logic [7:0] v,
		input logic s, output logic [31:0] d);
		logic [1:0] r;
		logic [7:0] f;
		f = frames + 8'h1;
		wr(LRQ_OFF_CMD, {8'h0, v, 4'h0, a, 3'h0, s, 1'b0, t}, r);
		settle(f, d);
	endtask
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [2:0] t;
		logic [7:0] f0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(LRQ_OFF_STAT, d, r);
		check("stat after reset", d, 32'h2);
		rd(8'h0c, d, r);
		check("unmapped rresp", {30'h0, r}, {30'h0, LRQ_RESP_SLVERR});
		wr(LRQ_OFF_STAT, 32'h1, r);
		check("stat write bresp", {30'h0, r}, {30'h0, LRQ_RESP_SLVERR});
		for (int i = 0; i < 10; i++) begin
			seed = xs(seed);
			t = {2'h2, seed[0]};
			if (i < 2) seed[23:8] = i ? 16'h0000 : 16'hff0f;
			req(t, seed[11:8], seed[23:16], 1'b0, d);
			check("reg frame", {15'h0, last_frame}, {15'h0, exp_frame(t, seed[11:8], seed[23:16], 1'b0)});
			if (t[0]) check("reg value", {24'h0, regs[seed[11:8]]}, {24'h0, seed[23:16]});
		end
		// Address and data bits of a bus command must not leak into the frame
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			t = i[2:0] & 3'h3;
			delay <= seed[27:24];
			wr(LRQ_OFF_LOST, 32'h0, r);
			req(t, seed[11:8], seed[23:16], seed[4], d);
			check("bus frame", {15'h0, last_frame}, {15'h0, exp_frame(t, 4'h0, 8'h0, seed[4])});
			check("won", {31'h0, d[4]}, 32'h1);
		end
		for (int i = 6; i < 8; i++) begin
			f0 = frames;
			wr(LRQ_OFF_CMD, {29'h0, i[2:0]}, r);
			repeat (40) @(posedge aclk);
			check("reserved type", {24'h0, frames}, {24'h0, f0});
		end
		lose <= 1'b1;
		delay <= 4'h2;
		wr(LRQ_OFF_LOST, 32'h0, r);
		f0 = frames + 8'h2;
		wr(LRQ_OFF_CMD, {29'h0, LRQ_FAIR}, r);
		d = 32'h0;
		while (d == 32'h0) rd(LRQ_OFF_LOST, d, r);
		lose <= 1'b0;
		check("lost count", d, 32'h1);
		settle(f0, d);
		check("resent won", {31'h0, d[4]}, 32'h1);
		check("resent frame", {15'h0, last_frame}, {15'h0, exp_frame(LRQ_FAIR, 4'h0, 8'h0, 1'b0)});
		tally_and_finish();
	end
endmodule
